// ==== rtl/cgif_pkg.sv ====
// Constants shared by the CAN global interrupt flag block.
package cgif_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned MBX_N = 32;
  localparam int unsigned VEC_W = 5;
  localparam int unsigned LINES = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FLAGS0 = 8'h00;
  localparam logic [7:0] OFS_FLAGS1 = 8'h04;
  localparam logic [7:0] OFS_GMASK = 8'h08;
  localparam logic [7:0] OFS_MMASK = 8'h0C;
  localparam logic [7:0] OFS_MLEVEL = 8'h10;
  localparam logic [7:0] OFS_TXACK = 8'h14;
  localparam logic [7:0] OFS_RXPEND = 8'h18;
  localparam logic [7:0] OFS_TOSTAT = 8'h1C;
  localparam logic [7:0] OFS_ABORTACK = 8'h20;
  localparam logic [7:0] OFS_RXLOST = 8'h24;
  localparam logic [7:0] OFS_CONFIG = 8'h28;

  // ****************************************************************
  // Flag register fields
  // ****************************************************************
  localparam int unsigned BIT_WARN = 8;
  localparam int unsigned BIT_PASSIVE = 9;
  localparam int unsigned BIT_BUSOFF = 10;
  localparam int unsigned BIT_LOST = 11;
  localparam int unsigned BIT_WAKE = 12;
  localparam int unsigned BIT_DENIED = 13;
  localparam int unsigned BIT_ABORT = 14;
  localparam int unsigned BIT_MBXEV = 15;
  localparam int unsigned BIT_STAMP = 16;
  localparam int unsigned BIT_TMO = 17;
  localparam int unsigned FLAG_LO = 8;
  localparam int unsigned FLAG_HI = 17;
  // Flags held in sticky flip-flops and cleared by a write of one.
  localparam logic [31:0] STICKY_MASK = 32'h0001_3700;

  // ****************************************************************
  // Global mask and configuration fields, reset values
  // ****************************************************************
  localparam int unsigned GM_LINE0_EN = 0;
  localparam int unsigned GM_LINE1_EN = 1;
  localparam int unsigned GM_LEVEL_SEL = 2;
  localparam logic [31:0] GM_WMASK = 32'h0003_FF07;
  localparam int unsigned CFG_STD = 0;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/cgif_top.sv ====
// CAN global interrupt flag logic with an AXI4-Lite register slave.
// Overview of operation
// - Global flags go to line-1 register when level select is 1 outside standard mode, else line-0.
// - Timeout, denied, bus-off, stamp, wake, passive, abort, lost, warning ignore masks.
// - Mailbox event flag only counts mailboxes whose mailbox mask bit is set.
// - A newly set flag raises its interrupt line when its mask bit and that line's enable bit are set.
// - Line stays active until flag cleared by CPU or its cause removed.
// - CPU clears flags by writing 1; writing 0 changes nothing.
// - Mailbox event flag ignores flag writes; cleared through tx-ack or rx-pending.
// - Clearing some flags while others remain enabled produces a fresh interrupt.
// - While mailbox event flag is set, vector field shows the causing mailbox.
// - With several pending mailboxes, vector shows the highest number on that line.
// - Timeout and mailbox event flags follow the mailbox level bit of their mailbox.
// - Timeout flag bit 17 set on mailbox timeout; absent in standard mode.
// - Timeout flag clears with timeout status; status clears on later success.
// - Stamp overflow flag bit 16 set when stamp counter MSB rises.
// - Mailbox event flag bit 15 set when a mailbox transmits or receives.
// - Flag bits 31:18 read as zero and ignore writes.
// - Line-1 flag register exists only outside standard compatibility mode.
// - Abort flag bit 14 clears when the set abort-ack bit is cleared.
// - Lost-message flag bit 11 clears when the set rx-pending bit is cleared.
// - Write-denied flag bit 13 set on identifier write to an enabled mailbox.
// - Bus-off flag bit 10 set when the controller enters bus-off.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module cgif_top
  import cgif_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-mailbox event pulses from the controller core.
  input wire logic [MBX_N-1:0] mbx_tx_done,
  input wire logic [MBX_N-1:0] mbx_rx_done,
  input wire logic [MBX_N-1:0] mbx_timeout,
  input wire logic [MBX_N-1:0] mbx_abort,
  input wire logic [MBX_N-1:0] mbx_rx_lost,
  // Module-level event pulses and the stamp counter MSB level.
  input wire logic id_write_denied,
  input wire logic wakeup_event,
  input wire logic bus_off_enter,
  input wire logic err_passive_enter,
  input wire logic warning_enter,
  input wire logic stamp_msb,
  // Interrupt lines.
  output logic irq_line0,
  output logic irq_line1
);

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic aw_hold;
  logic w_hold;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [31:0] wmask;
  logic wr_fire;
  logic [7:0] raddr;
  logic rd_flags_q;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;

  assign wr_fire = aw_hold & w_hold & ~s_axi_bvalid;
  assign raddr = {s_axi_araddr[7:2], 2'b00};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      waddr <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      waddr <= {s_axi_awaddr[7:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_hold <= 1'b0;
      wdata <= REG_RST;
      wmask <= REG_RST;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      wdata <= s_axi_wdata;
      wmask <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                {8{s_axi_wstrb[0]}}};
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    case (waddr)
      OFS_FLAGS0, OFS_FLAGS1, OFS_GMASK, OFS_MMASK, OFS_MLEVEL, OFS_TXACK,
      OFS_RXPEND, OFS_TOSTAT, OFS_ABORTACK, OFS_RXLOST, OFS_CONFIG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Bits written as one at a given offset, honouring byte strobes.
  function automatic logic [31:0] w1c(input logic [7:0] ofs, input logic fire,
                                     input logic [7:0] adr, input logic [31:0] d,
                                     input logic [31:0] m);
    return (fire && adr == ofs) ? (d & m) : 32'h0000_0000;
  endfunction

  // ****************************************************************
  // Software registers and mailbox status
  // ****************************************************************
  logic [31:0] gmask;
  logic [31:0] mmask;
  logic [31:0] mlevel;
  logic [31:0] cfg;
  logic [MBX_N-1:0] tx_ack;
  logic [MBX_N-1:0] rx_pend;
  logic [MBX_N-1:0] tostat;
  logic [MBX_N-1:0] abort_ack;
  logic [MBX_N-1:0] rx_lost;
  logic [MBX_N-1:0] clr_rx_pend;
  logic std_mode;
  logic level_sel_eff;
  logic [MBX_N-1:0] mlevel_eff;

  assign std_mode = cfg[CFG_STD];
  assign level_sel_eff = gmask[GM_LEVEL_SEL] & ~std_mode;
  assign mlevel_eff = std_mode ? '0 : mlevel;
  assign clr_rx_pend = rx_pend & w1c(OFS_RXPEND, wr_fire, waddr, wdata, wmask);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gmask <= REG_RST;
      mmask <= REG_RST;
      mlevel <= REG_RST;
      cfg <= REG_RST;
    end else if (wr_fire) begin
      case (waddr)
        OFS_GMASK: gmask <= (gmask & ~(wmask & GM_WMASK)) | (wdata & wmask & GM_WMASK);
        OFS_MMASK: mmask <= (mmask & ~wmask) | (wdata & wmask);
        OFS_MLEVEL: mlevel <= (mlevel & ~wmask) | (wdata & wmask);
        OFS_CONFIG: cfg[CFG_STD] <= wmask[CFG_STD] ? wdata[CFG_STD] : cfg[CFG_STD];
        default: gmask <= gmask;
      endcase
    end
  end

  // Hardware sets win over a same-cycle write of one.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_ack <= '0;
      rx_pend <= '0;
    end else begin
      tx_ack <= (tx_ack & ~w1c(OFS_TXACK, wr_fire, waddr, wdata, wmask)) | mbx_tx_done;
      rx_pend <= (rx_pend & ~clr_rx_pend) | mbx_rx_done;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tostat <= '0;
    end else begin
      // A later good transfer retires the timeout; a new timeout still wins.
      tostat <= (tostat & ~w1c(OFS_TOSTAT, wr_fire, waddr, wdata, wmask)
                 & ~(mbx_tx_done | mbx_rx_done)) | (mbx_timeout & {MBX_N{~std_mode}});
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      abort_ack <= '0;
      rx_lost <= '0;
    end else begin
      abort_ack <= (abort_ack & ~w1c(OFS_ABORTACK, wr_fire, waddr, wdata, wmask))
                   | mbx_abort;
      rx_lost <= (rx_lost & ~clr_rx_pend) | mbx_rx_lost;
    end
  end

  // ****************************************************************
  // Global event flags
  // ****************************************************************
  logic stamp_prev;
  logic [31:0] ev_bits;
  logic [31:0] sticky [LINES];
  logic [31:0] flag_word [LINES];
  logic [MBX_N-1:0] mbx_pend [LINES];
  logic [LINES-1:0] line_req;
  logic clr_hit;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stamp_prev <= 1'b0;
    end else begin
      stamp_prev <= stamp_msb;
    end
  end

  always_comb begin
    ev_bits = 32'h0000_0000;
    ev_bits[BIT_WARN] = warning_enter;
    ev_bits[BIT_PASSIVE] = err_passive_enter;
    ev_bits[BIT_BUSOFF] = bus_off_enter;
    ev_bits[BIT_WAKE] = wakeup_event;
    ev_bits[BIT_DENIED] = id_write_denied;
    ev_bits[BIT_STAMP] = stamp_msb & ~stamp_prev;
  end

  // Events set flags without looking at any mask; the mask only gates the line.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int l = 0; l < LINES; l++) begin
        sticky[l] <= REG_RST;
      end
    end else begin
      for (int l = 0; l < LINES; l++) begin
        sticky[l] <= ((sticky[l] & ~w1c(l == 0 ? OFS_FLAGS0 : OFS_FLAGS1, wr_fire, waddr,
                      wdata, wmask)) | (level_sel_eff == l[0] ? ev_bits : 32'h0000_0000))
                     & STICKY_MASK;
      end
    end
  end

  // Highest pending mailbox wins the vector.
  function automatic logic [VEC_W-1:0] top_mbx(input logic [MBX_N-1:0] v);
    logic [VEC_W-1:0] r;
    r = '0;
    for (int i = 0; i < MBX_N; i++) begin
      if (v[i]) begin
        r = VEC_W'(i);
      end
    end
    return r;
  endfunction

  // Abort, lost and timeout flags follow their status bits, so they fall by themselves.
  always_comb begin
    for (int l = 0; l < LINES; l++) begin
      mbx_pend[l] = (tx_ack | rx_pend) & mmask & (l == 0 ? ~mlevel_eff : mlevel_eff);
      flag_word[l] = sticky[l];
      flag_word[l][BIT_MBXEV] = |mbx_pend[l];
      flag_word[l][BIT_TMO] = ~std_mode
                              & |(tostat & (l == 0 ? ~mlevel_eff : mlevel_eff));
      flag_word[l][BIT_ABORT] = (level_sel_eff == l[0]) & |abort_ack;
      flag_word[l][BIT_LOST] = (level_sel_eff == l[0]) & |rx_lost;
      if (|mbx_pend[l]) begin
        flag_word[l][VEC_W-1:0] = top_mbx(mbx_pend[l]);
      end
    end
    if (std_mode) begin
      flag_word[1] = 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Interrupt lines
  // ****************************************************************
  // Any clearing write drops both lines for one cycle, so a line with flags
  // left standing shows a fresh rising edge to an edge-sensitive CPU.
  assign clr_hit = wr_fire && ((waddr == OFS_FLAGS0) || (waddr == OFS_FLAGS1)
                   || (waddr == OFS_TXACK) || (waddr == OFS_RXPEND)
                   || (waddr == OFS_TOSTAT) || (waddr == OFS_ABORTACK))
                   && |(wdata & wmask);

  always_comb begin
    line_req[0] = gmask[GM_LINE0_EN]
                  & |(flag_word[0][FLAG_HI:FLAG_LO] & gmask[FLAG_HI:FLAG_LO]);
    line_req[1] = gmask[GM_LINE1_EN] & ~std_mode
                  & |(flag_word[1][FLAG_HI:FLAG_LO] & gmask[FLAG_HI:FLAG_LO]);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_line0 <= 1'b0;
      irq_line1 <= 1'b0;
    end else begin
      irq_line0 <= line_req[0] & ~clr_hit;
      irq_line1 <= line_req[1] & ~clr_hit;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rd_ok = 1'b1;
    case (raddr)
      OFS_FLAGS0: rd_mux = flag_word[0];
      OFS_FLAGS1: rd_mux = flag_word[1];
      OFS_GMASK: rd_mux = gmask;
      OFS_MMASK: rd_mux = mmask;
      OFS_MLEVEL: rd_mux = mlevel;
      OFS_TXACK: rd_mux = tx_ack;
      OFS_RXPEND: rd_mux = rx_pend;
      OFS_TOSTAT: rd_mux = tostat;
      OFS_ABORTACK: rd_mux = abort_ack;
      OFS_RXLOST: rd_mux = rx_lost;
      OFS_CONFIG: rd_mux = cfg;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= REG_RST;
      s_axi_rresp <= RESP_OKAY;
      rd_flags_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rd_flags_q <= (raddr == OFS_FLAGS0) || (raddr == OFS_FLAGS1);
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [MBX_N-1:0] done_any;
  assign done_any = mbx_tx_done | mbx_rx_done;

  chk_irq0_cause: assert property (@(posedge core_clk) disable iff (!rstn)
    irq_line0 |-> $past(gmask[GM_LINE0_EN]) && !$past(clr_hit))
    else $error("Line 0 active without enable or during a clear.");
  chk_irq_gap: assert property (@(posedge core_clk) disable iff (!rstn)
    clr_hit |=> !irq_line0 && !irq_line1)
    else $error("Clearing write did not drop the interrupt lines.");
  chk_gmif_mask: assert property (@(posedge core_clk) disable iff (!rstn)
    flag_word[0][BIT_MBXEV] |-> |((tx_ack | rx_pend) & mmask))
    else $error("Mailbox event flag set with no unmasked mailbox.");
  chk_vector_src: assert property (@(posedge core_clk) disable iff (!rstn)
    flag_word[0][BIT_MBXEV] |-> mbx_pend[0][flag_word[0][VEC_W-1:0]])
    else $error("Vector names a mailbox that is not pending.");
  chk_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
    wakeup_event && !level_sel_eff |=> sticky[0][BIT_WAKE])
    else $error("Wake-up event lost.");
  chk_stamp_ovf: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(stamp_msb) && !level_sel_eff |=> flag_word[0][BIT_STAMP])
    else $error("Stamp overflow flag not set after MSB rise.");
  chk_std_line1: assert property (@(posedge core_clk) disable iff (!rstn)
    std_mode |-> flag_word[1] == 32'h0000_0000 && !line_req[1])
    else $error("Line-1 flags visible in standard mode.");
  chk_tos_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    |(tostat & done_any) |=> (tostat & $past(done_any) & ~$past(mbx_timeout)) == '0)
    else $error("Timeout status survived a good transfer.");
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    s_axi_rvalid && rd_flags_q |-> s_axi_rdata[31:18] == 14'h0000)
    else $error("Reserved flag bits read nonzero.");
  chk_wd_set: assert property (@(posedge core_clk) disable iff (!rstn)
    id_write_denied && level_sel_eff |=> flag_word[1][BIT_DENIED])
    else $error("Write-denied flag not set on line 1.");

endmodule

// ==== tb/cgif_core_model.sv ====
// Behavioural stand-in for the controller core that raises the event pulses.
`timescale 1ns/100ps
module cgif_core_model
  import cgif_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Event request from the bench.
  input wire logic [3:0] ev_kind,
  input wire logic [4:0] ev_mbx,
  input wire logic ev_go,
  // Event pulses and the stamp_msb level towards the flag block.
  output logic [MBX_N-1:0] mbx_tx_done,
  output logic [MBX_N-1:0] mbx_rx_done,
  output logic [MBX_N-1:0] mbx_timeout,
  output logic [MBX_N-1:0] mbx_abort,
  output logic [MBX_N-1:0] mbx_rx_lost,
  output logic id_write_denied,
  output logic wakeup_event,
  output logic bus_off_enter,
  output logic err_passive_enter,
  output logic warning_enter,
  output logic stamp_msb
);
  logic [10:0] hit;
  logic [4:0] mbx_q;
  logic [MBX_N-1:0] one_hot;
  // A request cycle becomes a pulse of exactly one cycle; kind 10 instead toggles the stamp_msb level, which the block sees until the next toggle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hit <= 11'h000;
      mbx_q <= 5'h00;
      stamp_msb <= 1'b0;
    end else begin
      hit <= ev_go ? (11'h001 << ev_kind) : 11'h000;
      mbx_q <= ev_mbx;
      if (hit[10]) begin
        stamp_msb <= ~stamp_msb;
      end
    end
  end
  assign one_hot = 32'h0000_0001 << mbx_q;
  assign mbx_tx_done = hit[0] ? one_hot : 32'h0000_0000;
  assign mbx_rx_done = hit[1] ? one_hot : 32'h0000_0000;
  assign mbx_timeout = hit[2] ? one_hot : 32'h0000_0000;
  assign mbx_abort = hit[3] ? one_hot : 32'h0000_0000;
  assign mbx_rx_lost = hit[4] ? one_hot : 32'h0000_0000;
  assign id_write_denied = hit[5];
  assign wakeup_event = hit[6];
  assign bus_off_enter = hit[7];
  assign err_passive_enter = hit[8];
  assign warning_enter = hit[9];
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the CAN global interrupt flag block.
`timescale 1ns/100ps
module tb_top
  import cgif_pkg::*;
;
  logic core_clk, rstn, irq_line0, irq_line1, irq_prev, ev_go;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rq;
  logic [3:0] s_axi_wstrb, ev_kind;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq, rsq;
  logic [MBX_N-1:0] mbx_tx_done, mbx_rx_done, mbx_timeout, mbx_abort, mbx_rx_lost;
  logic id_write_denied, wakeup_event, bus_off_enter, err_passive_enter, warning_enter;
  logic stamp_msb;
  logic [4:0] ev_mbx;
  int err_count, check_count, cyc, drops, d0;

  cgif_top #(.ADDR_W(8)) DUT (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mbx_tx_done, .mbx_rx_done, .mbx_timeout, .mbx_abort,
    .mbx_rx_lost, .id_write_denied, .wakeup_event, .bus_off_enter, .err_passive_enter,
    .warning_enter, .stamp_msb, .irq_line0, .irq_line1);
  cgif_core_model core (.core_clk, .rstn, .ev_kind, .ev_mbx, .ev_go, .mbx_tx_done,
    .mbx_rx_done, .mbx_timeout, .mbx_abort, .mbx_rx_lost, .id_write_denied, .wakeup_event,
    .bus_off_enter, .err_passive_enter, .warning_enter, .stamp_msb);

  // ****************************************************************
  // Clock, watchdog and helpers
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // A falling line counter shows the fresh interrupt after a partial clear.
  always @(posedge core_clk) begin
    irq_prev <= irq_line0;
    if (irq_prev === 1'b1 && irq_line0 === 1'b0) drops++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    bq = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rq = s_axi_rdata;
    rsq = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("register %h", a), rq, e);
  endtask
  // Kinds: 0 tx, 1 rx, 2 timeout, 3 abort, 4 lost, 5 denied, 6 wake, 7 bus-off,
  // 8 passive, 9 warning, 10 stamp MSB toggle.
  task automatic ev(input logic [3:0] k, input logic [4:0] m);
    ev_kind <= k;
    ev_mbx <= m;
    ev_go <= 1'b1;
    @(posedge core_clk);
    ev_go <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rstn, ev_go, ev_kind, ev_mbx, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {err_count, check_count, cyc, drops} = '0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdchk(OFS_FLAGS0, 32'h0000_0000);
    rdchk(OFS_FLAGS1, 32'h0000_0000);
    chk("rresp", {30'h0, rsq}, {30'h0, RESP_OKAY});
    wr(8'h2C, 32'hFFFF_FFFF);
    chk("bresp", {30'h0, bq}, {30'h0, RESP_SLVERR});
    rdchk(8'h2C, 32'h0000_0000);
    chk("rresp", {30'h0, rsq}, {30'h0, RESP_SLVERR});
    wr(OFS_GMASK, 32'h0000_0301);
    chk("bresp", {30'h0, bq}, {30'h0, RESP_OKAY});
    ev(4'h9, 5'h00);
    ev(4'h8, 5'h00);
    rdchk(OFS_FLAGS0, 32'h0000_0300);
    chk("irq0", {31'h0, irq_line0}, 32'h1);
    chk("irq1", {31'h0, irq_line1}, 32'h0);
    wr(OFS_FLAGS0, 32'h0000_0000);
    rdchk(OFS_FLAGS0, 32'h0000_0300);
    d0 = drops;
    wr(OFS_FLAGS0, 32'h0000_0100);
    repeat (3) @(posedge core_clk);
    chk("irq0 falls", drops, d0 + 1);
    chk("irq0", {31'h0, irq_line0}, 32'h1);
    rdchk(OFS_FLAGS0, 32'h0000_0200);
    wr(OFS_FLAGS0, 32'h0000_0200);
    repeat (3) @(posedge core_clk);
    chk("irq0", {31'h0, irq_line0}, 32'h0);
    ev(4'h6, 5'h00);
    ev(4'h5, 5'h00);
    ev(4'hA, 5'h00);
    ev(4'hA, 5'h00);
    rdchk(OFS_FLAGS0, 32'h0001_3000);
    chk("irq0", {31'h0, irq_line0}, 32'h0);
    // The wake-up pulse lands on the same edge as the clearing write.
    fork
      wr(OFS_FLAGS0, 32'hFFFF_3000);
      ev(4'h6, 5'h00);
    join
    rdchk(OFS_FLAGS0, 32'h0000_1000);
    wr(OFS_FLAGS0, 32'hFFFF_1000);
    rdchk(OFS_FLAGS0, 32'h0000_0000);
    wr(OFS_GMASK, 32'h0000_0406);
    ev(4'h7, 5'h00);
    ev(4'h5, 5'h00);
    rdchk(OFS_FLAGS1, 32'h0000_2400);
    rdchk(OFS_FLAGS0, 32'h0000_0000);
    chk("irq1", {31'h0, irq_line1}, 32'h1);
    chk("irq0", {31'h0, irq_line0}, 32'h0);
    wr(OFS_FLAGS1, 32'h0000_2400);
    rdchk(OFS_FLAGS1, 32'h0000_0000);
    wr(OFS_GMASK, 32'h0000_8003);
    wr(OFS_MMASK, 32'h0000_0288);
    wr(OFS_MLEVEL, 32'h0000_0080);
    ev(4'h0, 5'h03);
    ev(4'h1, 5'h07);
    ev(4'h0, 5'h05);
    rdchk(OFS_FLAGS0, 32'h0000_8003);
    rdchk(OFS_FLAGS1, 32'h0000_8007);
    chk("irq1", {31'h0, irq_line1}, 32'h1);
    ev(4'h0, 5'h09);
    rdchk(OFS_FLAGS0, 32'h0000_8009);
    wr(OFS_FLAGS0, 32'h0000_8000);
    rdchk(OFS_FLAGS0, 32'h0000_8009);
    wr(OFS_TXACK, 32'h0000_0200);
    rdchk(OFS_FLAGS0, 32'h0000_8003);
    wr(OFS_TXACK, 32'h0000_0028);
    rdchk(OFS_FLAGS0, 32'h0000_0000);
    wr(OFS_RXPEND, 32'h0000_0080);
    rdchk(OFS_FLAGS1, 32'h0000_0000);
    ev(4'h3, 5'h04);
    ev(4'h1, 5'h06);
    ev(4'h4, 5'h06);
    rdchk(OFS_FLAGS0, 32'h0000_4800);
    wr(OFS_ABORTACK, 32'h0000_0010);
    rdchk(OFS_FLAGS0, 32'h0000_0800);
    wr(OFS_RXPEND, 32'h0000_0040);
    rdchk(OFS_FLAGS0, 32'h0000_0000);
    ev(4'h2, 5'h07);
    rdchk(OFS_FLAGS1, 32'h0002_0000);
    ev(4'h1, 5'h07);
    rdchk(OFS_FLAGS1, 32'h0000_8007);
    wr(OFS_RXPEND, 32'h0000_0080);
    ev(4'h2, 5'h07);
    wr(OFS_TOSTAT, 32'h0000_0080);
    rdchk(OFS_FLAGS1, 32'h0000_0000);
    wr(OFS_CONFIG, 32'h0000_0001);
    ev(4'h2, 5'h07);
    rdchk(OFS_FLAGS0, 32'h0000_0000);
    ev(4'h1, 5'h07);
    rdchk(OFS_FLAGS0, 32'h0000_8007);
    rdchk(OFS_FLAGS1, 32'h0000_0000);
    chk("irq1", {31'h0, irq_line1}, 32'h0);
    close_out();
  end
endmodule
